// *** src/ebp_pkg.sv ***
/*
 * Constants shared by the external bus pin block: APB register map, field
 * positions, reset values and pin widths.
 * Assumes a 32-bit APB slave on pclk with active-low asynchronous presetn.
 */
package ebp_pkg;
	localparam int unsigned addr_w = 16;
	localparam int unsigned data_w = 16;
	localparam int unsigned iaddr_w = 20;
	// apb byte offsets
	localparam logic [7:0] reg_ctrl = 8'h00;
	localparam logic [7:0] reg_opaddr = 8'h04;
	localparam logic [7:0] reg_opdata = 8'h08;
	localparam logic [7:0] reg_iaddr = 8'h0c;
	localparam logic [7:0] reg_idata = 8'h10;
	localparam logic [7:0] reg_discr = 8'h14;
	localparam logic [7:0] reg_status = 8'h18;
	localparam logic [7:0] reg_rddata = 8'h1c;
	// ctrl fields
	localparam int unsigned ctrl_own = 0;
	localparam int unsigned ctrl_op_wr = 1;
	localparam int unsigned ctrl_i_wr = 2;
	// discrete fields: cs_n, od1, od2, od3 in bits 3..0
	localparam int unsigned discr_w = 4;
	localparam logic [3:0] discr_reset = 4'h9;
	// status fields
	localparam int unsigned st_mode = 0;
	localparam int unsigned st_test_n = 1;
	localparam int unsigned st_own = 2;
	localparam int unsigned st_rd_valid = 3;
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;
endpackage

// *** src/ebp_buf2.sv ***
/*
 * Two-entry valid/ready buffer for captured read words.
 * Assumes a single clock and active-low asynchronous reset.
 */
`timescale 1ns/10ps
module ebp_buf2 (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [15:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [15:0] out_data
);
	logic [15:0] mem [2];
	logic wp;
	logic rp;
	logic [1:0] cnt;
	logic push;
	logic pop;

	assign in_ready = (cnt != 2'h2);
	assign out_valid = (cnt != 2'h0);
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage; a stalled reader simply fills both slots
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem[0] <= 16'h0000;
			mem[1] <= 16'h0000;
		end else if (push) begin
			mem[wp] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push)
				wp <= ~wp;
			if (pop)
				rp <= ~rp;
			cnt <= cnt + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// *** src/ebp_pin_drv.sv ***
/*
 * One group of tri-state pins: registered value and output enable.
 * Assumes the caller decides when the group may drive.
 */
`timescale 1ns/10ps
module ebp_pin_drv #(
	parameter int unsigned w = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [w-1:0] value,
	input wire logic drive,
	output logic [w-1:0] pin_out,
	output logic pin_oe
);
	// both registered so pins change only on clock edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= '0;
			pin_oe <= 1'b0;
		end else begin
			pin_out <= value;
			pin_oe <= drive;
		end
	end
endmodule

// *** src/ebp_top.sv ***
/*
 * External bus pin block: operand bus, instruction bus with emulation
 * discretes, controlled by software over APB.
 * Assumes bus ownership comes from an arbiter outside, and that the
 * mode select input is strapped for the whole run.
 */
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module ebp_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_owned,
	input wire logic test_n,
	input wire logic emulation_mode_select,
	output logic [15:0] operand_addr_out,
	output logic operand_addr_oe,
	input wire logic [15:0] operand_data_in,
	output logic [15:0] operand_data_out,
	output logic operand_data_oe,
	output logic [15:0] instr_addr_out,
	output logic instr_addr_oe,
	output logic instr_addr16_or_discrete3,
	output logic instr_addr17_or_discrete2,
	output logic instr_addr18_or_discrete1,
	output logic instr_addr19_or_rom_select_n,
	output logic instr_upper_oe,
	input wire logic [15:0] instr_data_in,
	output logic [15:0] instr_data_out,
	output logic instr_data_oe,
	input wire logic output_register_instruction,
	input wire logic [3:0] output_register_value
);
	logic [31:0] ctrl;
	logic [15:0] op_addr;
	logic [15:0] op_wdata;
	logic [19:0] i_addr;
	logic [15:0] i_wdata;
	logic [3:0] discr;
	logic setup;
	logic access;
	logic wr_en;
	logic rd_en;
	logic drive_op;
	logic drive_op_data;
	logic drive_i_data;
	logic [3:0] next_upper;
	logic [15:0] ia_low;
	logic [3:0] ia_up;
	logic up_oe;
	logic cap_valid;
	logic cap_ready;
	logic [15:0] cap_data;
	logic rd_valid;
	logic rd_pop;
	logic [15:0] rd_word;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_en = access && pwrite;
	assign rd_en = access && !pwrite;

	// apb answers in the access cycle itself, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup && (paddr[1:0] != 2'h0 ||
				paddr > ebp_pkg::reg_rddata);
		end
	end

	// software control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= ebp_pkg::ctrl_reset;
			op_addr <= 16'h0000;
			op_wdata <= 16'h0000;
			i_addr <= 20'h00000;
			i_wdata <= 16'h0000;
		end else if (wr_en && pready) begin
			unique case (paddr)
				ebp_pkg::reg_ctrl: ctrl <= pwdata;
				ebp_pkg::reg_opaddr: op_addr <= pwdata[15:0];
				ebp_pkg::reg_opdata: op_wdata <= pwdata[15:0];
				ebp_pkg::reg_iaddr: i_addr <= pwdata[19:0];
				ebp_pkg::reg_idata: i_wdata <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// discretes move only on the output-register instruction, never
	// by a plain bus write, so software cannot bypass the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			discr <= ebp_pkg::discr_reset;
		else if (output_register_instruction)
			discr <= output_register_value;
	end

	// read mux, registered so prdata comes straight from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			unique case (paddr)
				ebp_pkg::reg_ctrl: prdata <= ctrl;
				ebp_pkg::reg_opaddr: prdata <= {16'h0000, op_addr};
				ebp_pkg::reg_opdata: prdata <= {16'h0000, op_wdata};
				ebp_pkg::reg_iaddr: prdata <= {12'h000, i_addr};
				ebp_pkg::reg_idata: prdata <= {16'h0000, i_wdata};
				ebp_pkg::reg_discr: prdata <= {28'h0000000, discr};
				ebp_pkg::reg_status: prdata <= {28'h0000000, rd_valid,
					bus_owned, test_n, emulation_mode_select};
				ebp_pkg::reg_rddata: prdata <= {15'h0000, rd_valid,
					rd_word};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// a read of the data register pops one captured word
	assign rd_pop = rd_en && pready && (paddr == ebp_pkg::reg_rddata);

	// operand pins only when owned by arbitration and not in test
	assign drive_op = bus_owned && ctrl[ebp_pkg::ctrl_own] && test_n;
	assign drive_op_data = drive_op && ctrl[ebp_pkg::ctrl_op_wr];
	// instruction data ignores ownership: test or a clear ctrl_i_wr bit floats it
	assign drive_i_data = test_n && ctrl[ebp_pkg::ctrl_i_wr];

	// upper instruction outputs: address in native, discretes in emulation
	always_comb begin
		if (emulation_mode_select)
			next_upper = discr;
		else
			next_upper = i_addr[19:16];
	end

	ebp_pin_drv #(.w(16)) u_op_addr (
		.pclk(pclk),
		.presetn(presetn),
		.value(op_addr),
		.drive(drive_op),
		.pin_out(operand_addr_out),
		.pin_oe(operand_addr_oe)
	);

	ebp_pin_drv #(.w(16)) u_op_data (
		.pclk(pclk),
		.presetn(presetn),
		.value(op_wdata),
		.drive(drive_op_data),
		.pin_out(operand_data_out),
		.pin_oe(operand_data_oe)
	);

	ebp_pin_drv #(.w(16)) u_i_addr (
		.pclk(pclk),
		.presetn(presetn),
		.value(i_addr[15:0]),
		.drive(test_n),
		.pin_out(ia_low),
		.pin_oe(instr_addr_oe)
	);
	assign instr_addr_out = ia_low;

	ebp_pin_drv #(.w(4)) u_i_upper (
		.pclk(pclk),
		.presetn(presetn),
		.value(next_upper),
		.drive(test_n),
		.pin_out(ia_up),
		.pin_oe(up_oe)
	);
	assign instr_addr19_or_rom_select_n = ia_up[3];
	assign instr_addr18_or_discrete1 = ia_up[2];
	assign instr_addr17_or_discrete2 = ia_up[1];
	assign instr_addr16_or_discrete3 = ia_up[0];
	assign instr_upper_oe = up_oe;

	ebp_pin_drv #(.w(16)) u_i_data (
		.pclk(pclk),
		.presetn(presetn),
		.value(i_wdata),
		.drive(drive_i_data),
		.pin_out(instr_data_out),
		.pin_oe(instr_data_oe)
	);

	// capture instruction data each cycle the stage is empty or the buffer takes its word; a word is
	// offered only while nobody drives the pins and not in test
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_valid <= 1'b0;
			cap_data <= 16'h0000;
		end else if (!cap_valid || cap_ready) begin
			cap_valid <= test_n && !instr_data_oe && !drive_i_data;
			cap_data <= instr_data_in;
		end
	end

	ebp_buf2 u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(cap_valid),
		.in_ready(cap_ready),
		.in_data(cap_data),
		.out_valid(rd_valid),
		.out_ready(rd_pop),
		.out_data(rd_word)
	);
endmodule

// *** bench/ebp_top_assertions.sv ***
/* checker of pin enables and discretes of ebp_top
 sees only top ports, pclk domain */
`timescale 1ns/10ps
module ebp_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bus_owned,
	input wire logic test_n,
	input wire logic emulation_mode_select,
	input wire logic operand_addr_oe,
	input wire logic operand_data_oe,
	input wire logic instr_addr_oe,
	input wire logic instr_upper_oe,
	input wire logic instr_data_oe,
	input wire logic output_register_instruction,
	input wire logic instr_addr16_or_discrete3,
	input wire logic instr_addr17_or_discrete2,
	input wire logic instr_addr18_or_discrete1,
	input wire logic instr_addr19_or_rom_select_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// upper four pins, rom select on top
	wire logic [3:0] up = {instr_addr19_or_rom_select_n,
		instr_addr18_or_discrete1, instr_addr17_or_discrete2,
		instr_addr16_or_discrete3};
	sequence load_s;
		$past(output_register_instruction) ||
		$past(output_register_instruction, 2);
	endsequence
	op_addr_own_a: assert property (operand_addr_oe |->
		$past(bus_owned) && $past(test_n)) else $error("op addr drive");
	op_data_own_a: assert property (operand_data_oe |->
		operand_addr_oe) else $error("op data drive");
	op_data_test_a: assert property (operand_data_oe |->
		$past(test_n)) else $error("op data test");
	// sampled presetn keeps the release edge out: pins still reset there
	iaddr_test_a: assert property (presetn |=>
		instr_addr_oe == $past(test_n)) else $error("iaddr oe");
	upper_test_a: assert property (presetn |=>
		instr_upper_oe == $past(test_n)) else $error("upper oe");
	idata_test_a: assert property (instr_data_oe |->
		$past(test_n)) else $error("idata oe");
	// reset edges excluded: pins leave zero then
	discr_hold_a: assert property ($past(presetn, 3) &&
		emulation_mode_select && $changed(up) |-> load_s)
		else $error("discrete moved");
	discr_reset_a: assert property ($rose(presetn) &&
		emulation_mode_select |-> ##2 up == 4'h9)
		else $error("discrete reset");
endmodule
bind ebp_top ebp_chk chk (.pclk, .presetn, .bus_owned, .test_n,
	.emulation_mode_select, .operand_addr_oe, .operand_data_oe,
	.instr_addr_oe, .instr_upper_oe, .instr_data_oe,
	.output_register_instruction, .instr_addr16_or_discrete3,
	.instr_addr17_or_discrete2, .instr_addr18_or_discrete1,
	.instr_addr19_or_rom_select_n);

// *** bench/ebp_mem.sv ***
/* far side: instruction memory or rom, operand bus
 assumes device enables are high while it drives */
`timescale 1ns/10ps
module ebp_mem (
	input wire logic pclk,
	input wire logic emulation_mode_select,
	input wire logic [15:0] instr_addr_out,
	input wire logic instr_addr19_or_rom_select_n,
	input wire logic [15:0] instr_data_out,
	input wire logic instr_data_oe,
	input wire logic [15:0] operand_data_out,
	input wire logic operand_data_oe,
	output logic [15:0] instr_data_in,
	output logic [15:0] operand_data_in
);
	logic [15:0] idle = 16'h3c3c;
	// undriven lines wander, so stale values never match
	always @(posedge pclk) begin
		idle <= ~idle;
	end
	// memory answers only while the device releases the line
	always_comb begin
		if (instr_data_oe) begin
			instr_data_in = instr_data_out;
		end else if (emulation_mode_select &&
			instr_addr19_or_rom_select_n) begin
			instr_data_in = idle;
		end else begin
			instr_data_in = instr_addr_out ^ 16'h5a5a;
		end
		// no other master drives here
		operand_data_in = operand_data_oe ? operand_data_out : idle;
	end
endmodule

// *** bench/ebp_top_tb.sv ***
/* bench of ebp_top: register rows, pins, capture, emulation
 assumes ebp_mem at far side, checker bound */
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin \
 error_cnt++; $display("mismatch %s exp %h got %h", n, e, a); end end
module ebp_top_tb;
	typedef struct {logic [7:0] a; logic [31:0] d, e; logic r;} ebp_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic bus_owned, test_n, emulation_mode_select;
	logic operand_addr_oe, operand_data_oe, instr_addr_oe;
	logic instr_upper_oe, instr_data_oe, output_register_instruction;
	logic instr_addr16_or_discrete3, instr_addr17_or_discrete2;
	logic instr_addr18_or_discrete1, instr_addr19_or_rom_select_n;
	logic [15:0] operand_addr_out, operand_data_in, operand_data_out;
	logic [15:0] instr_addr_out, instr_data_in, instr_data_out;
	logic [3:0] output_register_value;
	int error_cnt = 0, checked = 0, cyc = 0;
	ebp_row_t rows[8] = '{'{8'h04, 32'h0000a5c3, 32'h0000a5c3, 0},
		'{8'h08, 32'h00008001, 32'h00008001, 0},
		'{8'h0c, 32'hfff12345, 32'h00012345, 0},
		'{8'h10, 32'h00017e81, 32'h00007e81, 0},
		'{8'h14, 32'hffffffff, 32'h00000009, 0},
		'{8'h20, 32'h1, 32'h0, 1}, '{8'h02, 32'h1, 32'h0, 1},
		'{8'h00, 32'h7, 32'h7, 0}};
	wire logic [3:0] up = {instr_addr19_or_rom_select_n,
		instr_addr18_or_discrete1, instr_addr17_or_discrete2,
		instr_addr16_or_discrete3};
	wire logic [4:0] oes = {operand_addr_oe, operand_data_oe,
		instr_addr_oe, instr_upper_oe, instr_data_oe};
	ebp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .bus_owned, .test_n,
		.emulation_mode_select, .operand_addr_out, .operand_addr_oe,
		.operand_data_in, .operand_data_out, .operand_data_oe,
		.instr_addr_out, .instr_addr_oe, .instr_addr16_or_discrete3,
		.instr_addr17_or_discrete2, .instr_addr18_or_discrete1,
		.instr_addr19_or_rom_select_n, .instr_upper_oe, .instr_data_in,
		.instr_data_out, .instr_data_oe, .output_register_instruction,
		.output_register_value);
	ebp_mem mem (.pclk, .emulation_mode_select, .instr_addr_out,
		.instr_addr19_or_rom_select_n, .instr_data_out, .instr_data_oe,
		.operand_data_out, .operand_data_oe, .instr_data_in,
		.operand_data_in);
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	task print_verdict();
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, far above the roughly 130 cycles needed
	initial begin
		forever @(posedge pclk) begin
			cyc++;
			if (cyc == 20000) begin
				error_cnt++;
				print_verdict();
			end
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// pready ends this wait; only the hang guard ends it if pready never rises
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// mode only changes under reset
	task rst(input logic m);
		presetn <= 1'b0;
		emulation_mode_select <= m;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, bus_owned} = '0;
		{output_register_instruction, output_register_value} = '0;
		{presetn, emulation_mode_select, test_n} = 3'b001;
		rst(1'b0);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			`CHK("pslverr", rows[i].r, err)
			if (!rows[i].r) `CHK("prdata", rows[i].e, rd)
		end
		$display("rows done");
		bus_owned <= 1'b1;
		repeat (3) @(posedge pclk);
		`CHK("oes", 5'h1f, oes)
		`CHK("op_addr", 16'ha5c3, operand_addr_out)
		`CHK("op_data", 16'h8001, operand_data_out)
		`CHK("i_addr", 16'h2345, instr_addr_out)
		`CHK("upper", 4'h1, up)
		`CHK("i_data", 16'h7e81, instr_data_out)
		test_n <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK("test float", 5'h0, oes)
		test_n <= 1'b1;
		bus_owned <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK("no owner", 5'h07, oes)
		$display("pins done");
		test_n <= 1'b0;
		repeat (3) apb(1'b0, 8'h1c, 32'h0);
		apb(1'b1, 8'h00, 32'h3);
		test_n <= 1'b1;
		repeat (6) @(posedge pclk);
		test_n <= 1'b0;
		apb(1'b0, 8'h18, 32'h0);
		`CHK("status", 32'h8, rd)
		// two buffer slots plus the capture stage hold three words
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, 8'h1c, 32'h0);
			`CHK("valid", k < 3, rd[16])
			if (k < 3) `CHK("word", 16'h791f, rd[15:0])
		end
		test_n <= 1'b1;
		$display("capture done");
		rst(1'b1);
		repeat (3) @(posedge pclk);
		`CHK("discr rst", 4'h9, up)
		apb(1'b1, 8'h0c, 32'h000f0000);
		repeat (3) @(posedge pclk);
		`CHK("discr hold", 4'h9, up)
		output_register_instruction <= 1'b1;
		output_register_value <= 4'h6;
		@(posedge pclk);
		output_register_instruction <= 1'b0;
		repeat (3) @(posedge pclk);
		`CHK("discr set", 4'h6, up)
		apb(1'b0, 8'h14, 32'h0);
		`CHK("discr reg", 32'h6, rd)
		$display("emulation done");
		print_verdict();
	end
endmodule
